/* hw/hsi_top.sv */
// Purpose: serial target port with the hub interrupt and charger mode registers
// Assumes: scl and sda pins are slow against the 100 MHz clock
// Notes:   a pointer byte selects the register; it increments per data byte
//
// Function
// - status bit 7 shows pin pulled by event
// - writing 0 to bit 7 releases pin
// - hub entering suspend sets bit 4
// - event flags stay set until cleared
// - write 0 clears flag, write 1 ignored
// - host configuring hub sets bit 3
// - port power register update sets bit 2
// - charger found going low sets bit 1
// - detection complete going high sets bit 0
// - enable bits let events pull pin low
// - address bits 6:1 from low register when select1=0
// - address bits 6:1 from high register when select1=1
// - address lsb follows select0; reserved bits
// - enable bit starts detection on stage entry
// - enhanced bit reverses data line source
// - charger mode register resets to 0x14
// - pin stays event interrupt unless suspend-level chosen
`default_nettype none

module hsi_top
  import hsi_pkg::*;
#(
  parameter logic [7:0] TARGET_ADDR_LOW  = RST_ADDR_LOW,
  parameter logic [7:0] TARGET_ADDR_HIGH = RST_ADDR_HIGH
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  // serial target port
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic addr_select_0,
  input  wire logic addr_select_1,
  // hub status
  input  wire logic hub_suspended,
  input  wire logic hub_configured,
  input  wire logic port_power_update,
  input  wire logic charger_found_n,
  input  wire logic charger_scan_done,
  input  wire logic charger_scan_stage,
  input  wire logic refclk_wait_stage,
  input  wire logic refclk_present,
  input  wire logic suspend_level_irq_select,
  // interrupt and charger control
  output logic      irq_n,
  output logic      charger_scan_start,
  output logic      charger_scan_enable,
  output logic      data_line_voltage_source
);

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  if (((TARGET_ADDR_LOW | TARGET_ADDR_HIGH) & ADDR_RSVD_MASK) != 8'h00) begin
    $error("target address registers must keep bits 7 and 0 at zero");
  end

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WACK,
    ST_RDATA,
    ST_RACK
  } hsi_phase_t;

  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic [1:0] asel0_sync;
    logic [1:0] asel1_sync;
    hsi_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic       rw;
    logic       nack;
    logic       oe;
    logic       drive_level;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } hsi_port_state_t;

  localparam hsi_port_state_t PORT_RST = '{
    scl_sync:    3'h7,
    sda_sync:    3'h7,
    asel0_sync:  2'h0,
    asel1_sync:  2'h0,
    phase:       ST_IDLE,
    bitcnt:      4'h0,
    shreg:       8'h00,
    ptr:         8'h00,
    rw:          1'b0,
    nack:        1'b0,
    oe:          1'b0,
    drive_level: 1'b0,
    wr_en:       1'b0,
    wr_addr:     8'h00,
    wr_data:     8'h00
  };

  hsi_port_state_t q;
  hsi_port_state_t next_q;
  hsi_reg_if       rb ();

  // address registers are constants; the rest come from the event core
  function automatic logic [7:0] read_reg(input logic [7:0] ofs,
                                          input logic [7:0] core_data);
    case (ofs)
      OFS_ADDR_LOW:  read_reg = TARGET_ADDR_LOW & ~ADDR_RSVD_MASK;
      OFS_ADDR_HIGH: read_reg = TARGET_ADDR_HIGH & ~ADDR_RSVD_MASK;
      default:       read_reg = core_data;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // serial target engine
  // --------------------------------------------------------------------------
  always_comb begin
    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;
    logic       sda_now;
    logic [6:0] my_addr;
    logic [7:0] rdv;
    next_q = q;
    next_q.scl_sync   = {q.scl_sync[1:0], scl_in};
    next_q.sda_sync   = {q.sda_sync[1:0], sda_in};
    next_q.asel0_sync = {q.asel0_sync[0], addr_select_0};
    next_q.asel1_sync = {q.asel1_sync[0], addr_select_1};
    next_q.wr_en      = 1'b0;
    // stage 1 is the synchronised level, stage 2 the previous one
    scl_rise   = q.scl_sync[1] & ~q.scl_sync[2];
    scl_fall   = ~q.scl_sync[1] & q.scl_sync[2];
    start_cond = q.scl_sync[1] & q.scl_sync[2] &
                 q.sda_sync[2] & ~q.sda_sync[1];
    stop_cond  = q.scl_sync[1] & q.scl_sync[2] &
                 ~q.sda_sync[2] & q.sda_sync[1];
    sda_now    = q.sda_sync[1];
    my_addr    = {(q.asel1_sync[1] ? TARGET_ADDR_HIGH[6:1]
                                   : TARGET_ADDR_LOW[6:1]),
                  q.asel0_sync[1]};
    rdv        = read_reg(q.ptr, rb.rd_data);
    if (start_cond) begin
      next_q.phase  = ST_ADDR;
      next_q.bitcnt = 4'h0;
      next_q.oe     = 1'b0;
    end else if (stop_cond) begin
      next_q.phase = ST_IDLE;
      next_q.oe    = 1'b0;
    end else begin
      case (q.phase)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            next_q.shreg  = {q.shreg[6:0], sda_now};
            next_q.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == BITS_PER_BYTE) begin
            next_q.bitcnt = 4'h0;
            next_q.oe     = 1'b1;
            if (q.phase == ST_ADDR) begin
              next_q.rw = q.shreg[0];
              if (q.shreg[7:1] == my_addr) begin
                next_q.phase = ST_ADDR_ACK;
              end else begin
                // another target is addressed: stay off the bus
                next_q.phase = ST_IDLE;
                next_q.oe    = 1'b0;
              end
            end else if (q.phase == ST_PTR) begin
              next_q.ptr   = q.shreg;
              next_q.phase = ST_PTR_ACK;
            end else begin
              next_q.wr_en   = 1'b1;
              next_q.wr_addr = q.ptr;
              next_q.wr_data = q.shreg;
              next_q.ptr     = q.ptr + 8'h01;
              next_q.phase   = ST_WACK;
            end
          end
        end
        ST_ADDR_ACK, ST_PTR_ACK, ST_WACK: begin
          if (scl_fall) begin
            next_q.oe = 1'b0;
            if (q.phase == ST_ADDR_ACK && q.rw) begin
              next_q.shreg  = rdv;
              next_q.oe     = ~rdv[7];
              next_q.bitcnt = 4'h1;
              next_q.phase  = ST_RDATA;
            end else if (q.phase == ST_ADDR_ACK) begin
              next_q.phase = ST_PTR;
            end else begin
              next_q.phase = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (q.bitcnt == BITS_PER_BYTE) begin
              next_q.oe    = 1'b0;
              next_q.ptr   = q.ptr + 8'h01;
              next_q.phase = ST_RACK;
            end else begin
              next_q.oe     = ~q.shreg[6];
              next_q.shreg  = {q.shreg[6:0], 1'b0};
              next_q.bitcnt = q.bitcnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            next_q.nack = sda_now;
          end else if (scl_fall) begin
            if (q.nack) begin
              // controller is done reading: wait for stop or start
              next_q.phase = ST_IDLE;
            end else begin
              next_q.shreg  = rdv;
              next_q.oe     = ~rdv[7];
              next_q.bitcnt = 4'h1;
              next_q.phase  = ST_RDATA;
            end
          end
        end
        default: begin
          next_q.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= PORT_RST;
    end else begin
      q <= next_q;
    end
  end

  // --------------------------------------------------------------------------
  // register path and event core
  // --------------------------------------------------------------------------
  assign rb.wr_en   = q.wr_en;
  assign rb.wr_addr = q.wr_addr;
  assign rb.wr_data = q.wr_data;
  assign rb.rd_addr = q.ptr;

  hsi_event_core u_core (
    .clock                    (clock),
    .arst_n                   (arst_n),
    .rb                       (rb),
    .hub_suspended            (hub_suspended),
    .hub_configured           (hub_configured),
    .port_power_update        (port_power_update),
    .charger_found_n          (charger_found_n),
    .charger_scan_done        (charger_scan_done),
    .charger_scan_stage       (charger_scan_stage),
    .refclk_wait_stage        (refclk_wait_stage),
    .refclk_present           (refclk_present),
    .suspend_level_irq_select (suspend_level_irq_select),
    .irq_n                    (irq_n),
    .charger_scan_start       (charger_scan_start),
    .charger_scan_enable      (charger_scan_enable),
    .charger_scan_enhanced    (data_line_voltage_source)
  );

  // open-drain: the pin is only ever pulled low
  assign sda_out = q.drive_level;
  assign sda_oe  = q.oe;

endmodule

`default_nettype wire

/* hw/hsi_pkg.sv */
// Purpose: shared constants for the hub serial interrupt and charger mode block
// Assumes: 8-bit registers reached over the two-wire target port
// Notes:   offsets are the register pointer values used on the serial port
`default_nettype none

package hsi_pkg;

  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'hE8;
  localparam logic [7:0] OFS_IRQ_ENABLE  = 8'hE9;
  localparam logic [7:0] OFS_ADDR_LOW    = 8'hEA;
  localparam logic [7:0] OFS_ADDR_HIGH   = 8'hEB;
  localparam logic [7:0] OFS_CHG_MODE    = 8'hEC;

  // --------------------------------------------------------------------------
  // field positions and widths
  // --------------------------------------------------------------------------
  localparam int unsigned NUM_EVENTS     = 5;
  localparam int unsigned BIT_SUMMARY    = 7;
  localparam int unsigned BIT_SUSPEND    = 4;
  localparam int unsigned BIT_CONFIGURED = 3;
  localparam int unsigned BIT_PORT_POWER = 2;
  localparam int unsigned BIT_CHG_FOUND  = 1;
  localparam int unsigned BIT_CHG_DONE   = 0;
  localparam int unsigned BIT_SCAN_EN    = 4;
  localparam int unsigned BIT_SCAN_ENH   = 2;

  // --------------------------------------------------------------------------
  // reset values and writable masks
  // --------------------------------------------------------------------------
  localparam logic [7:0] RST_IRQ_STATUS  = 8'h00;
  localparam logic [4:0] RST_IRQ_ENABLE  = 5'h00;
  localparam logic [7:0] RST_ADDR_LOW    = 8'h08;
  localparam logic [7:0] RST_ADDR_HIGH   = 8'h28;
  localparam logic [7:0] RST_CHG_MODE    = 8'h14;
  localparam logic [7:0] CHG_MODE_WMASK  = 8'h14;
  localparam logic [7:0] ADDR_RSVD_MASK  = 8'h81;

  // --------------------------------------------------------------------------
  // serial port framing
  // --------------------------------------------------------------------------
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

endpackage

`default_nettype wire

/* hw/hsi_reg_if.sv */
// Purpose: register access path between the serial engine and the event core
// Assumes: one clock; write is a one-cycle strobe, read data is combinational
// Notes:   read and write addresses are separate so a write never races a read
`default_nettype none

interface hsi_reg_if;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  modport bus  (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport core (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

`default_nettype wire

/* hw/hsi_event_core.sv */
// Purpose: sticky event flags, enables, summary interrupt and charger mode
// Assumes: hub event inputs come from logic on the same clock
// Notes:   an event in the cycle of its clearing write keeps its flag set
`default_nettype none

module hsi_event_core
  import hsi_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  // register path
  hsi_reg_if.core   rb,
  // hub events
  input  wire logic hub_suspended,
  input  wire logic hub_configured,
  input  wire logic port_power_update,
  input  wire logic charger_found_n,
  input  wire logic charger_scan_done,
  input  wire logic charger_scan_stage,
  input  wire logic refclk_wait_stage,
  input  wire logic refclk_present,
  input  wire logic suspend_level_irq_select,
  // outputs
  output logic      irq_n,
  output logic      charger_scan_start,
  output logic      charger_scan_enable,
  output logic      charger_scan_enhanced
);

  typedef struct packed {
    logic [NUM_EVENTS-1:0] flags;
    logic [NUM_EVENTS-1:0] enables;
    logic                  pending;
    logic [7:0]            mode;
    logic                  prev_susp;
    logic                  prev_found_n;
    logic                  prev_done;
    logic                  prev_stage;
    logic                  prev_wait_noref;
    logic                  irq_n;
    logic                  start;
  } hsi_core_state_t;

  localparam hsi_core_state_t CORE_RST = '{
    flags:           RST_IRQ_STATUS[NUM_EVENTS-1:0],
    enables:         RST_IRQ_ENABLE,
    pending:         RST_IRQ_STATUS[BIT_SUMMARY],
    mode:            RST_CHG_MODE,
    prev_susp:       1'b0,
    prev_found_n:    1'b1,
    prev_done:       1'b0,
    prev_stage:      1'b0,
    prev_wait_noref: 1'b0,
    irq_n:           1'b1,
    start:           1'b0
  };

  hsi_core_state_t q;
  hsi_core_state_t next_q;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic [NUM_EVENTS-1:0] ev;
    logic [NUM_EVENTS-1:0] clr;
    logic                  pclr;
    logic                  wait_noref;
    ev         = '0;
    clr        = '0;
    pclr       = 1'b0;
    wait_noref = refclk_wait_stage & ~refclk_present;
    next_q     = q;
    ev[BIT_SUSPEND]    = hub_suspended & ~q.prev_susp;
    ev[BIT_CONFIGURED] = hub_configured;
    ev[BIT_PORT_POWER] = port_power_update;
    ev[BIT_CHG_FOUND]  = q.prev_found_n & ~charger_found_n;
    ev[BIT_CHG_DONE]   = charger_scan_done & ~q.prev_done;
    if (rb.wr_en) begin
      case (rb.wr_addr)
        OFS_IRQ_STATUS: begin
          clr  = ~rb.wr_data[NUM_EVENTS-1:0];
          pclr = ~rb.wr_data[BIT_SUMMARY];
        end
        OFS_IRQ_ENABLE: begin
          next_q.enables = rb.wr_data[NUM_EVENTS-1:0];
        end
        OFS_CHG_MODE: begin
          next_q.mode = rb.wr_data & CHG_MODE_WMASK;
        end
        default: begin
        end
      endcase
    end
    // set wins over clear so no event is lost
    next_q.flags   = (q.flags & ~clr) | ev;
    next_q.pending = (q.pending & ~pclr) | (|(ev & q.enables));
    // with suspend-level select low, summary bit and pin move together
    next_q.irq_n = suspend_level_irq_select ? ~hub_suspended
                                            : ~next_q.pending;
    next_q.start = q.mode[BIT_SCAN_EN] &
                   ((charger_scan_stage & ~q.prev_stage) |
                    (wait_noref & ~q.prev_wait_noref));
    next_q.prev_susp       = hub_suspended;
    next_q.prev_found_n    = charger_found_n;
    next_q.prev_done       = charger_scan_done;
    next_q.prev_stage      = charger_scan_stage;
    next_q.prev_wait_noref = wait_noref;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= CORE_RST;
    end else begin
      q <= next_q;
    end
  end

  // --------------------------------------------------------------------------
  // read data and outputs
  // --------------------------------------------------------------------------
  always_comb begin
    case (rb.rd_addr)
      OFS_IRQ_STATUS: rb.rd_data = {q.pending, 2'h0, q.flags};
      OFS_IRQ_ENABLE: rb.rd_data = {3'h0, q.enables};
      OFS_CHG_MODE:   rb.rd_data = q.mode;
      default:        rb.rd_data = 8'h00;
    endcase
  end

  assign irq_n                 = q.irq_n;
  assign charger_scan_start    = q.start;
  assign charger_scan_enable   = q.mode[BIT_SCAN_EN];
  assign charger_scan_enhanced = q.mode[BIT_SCAN_ENH];

endmodule

`default_nettype wire

/* test/hsi_top_assertions.sv */
// Purpose: port-level checks on interrupt and charger start behaviour
// Assumes: bound into hsi_top; one clock domain
// Notes:   register contents are hidden, so checks tie pins to pin causes
`default_nettype none

module hsi_top_checker (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // inputs of the block
  input wire logic scl_in,
  input wire logic hub_suspended,
  input wire logic hub_configured,
  input wire logic port_power_update,
  input wire logic charger_found_n,
  input wire logic charger_scan_done,
  input wire logic charger_scan_stage,
  input wire logic refclk_wait_stage,
  input wire logic refclk_present,
  input wire logic suspend_level_irq_select,
  // outputs of the block
  input wire logic irq_n,
  input wire logic charger_scan_start,
  input wire logic charger_scan_enable,
  input wire logic data_line_voltage_source
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  // --------------------
  // charger start
  // --------------------
  sequence s_stage_entry;
    $rose(charger_scan_stage) && charger_scan_enable;
  endsequence

  sequence s_wait_entry;
    $rose(refclk_wait_stage && !refclk_present) && charger_scan_enable;
  endsequence

  a_mode_reset: assert property (
    $rose(arst_n) |-> charger_scan_enable && data_line_voltage_source)
    else $error("charger mode pins not at reset value");
  a_stage_start: assert property (s_stage_entry |=> charger_scan_start)
    else $error("no start on detection stage entry");
  a_wait_start: assert property (s_wait_entry |=> charger_scan_start)
    else $error("no start in clock wait stage");
  a_start_cause: assert property (
    charger_scan_start |-> $past(charger_scan_enable) &&
      ($past(charger_scan_stage) ||
       $past(refclk_wait_stage && !refclk_present)))
    else $error("start without enabled stage");
  a_start_single: assert property (
    charger_scan_start |=> !charger_scan_start)
    else $error("start longer than one cycle");

  // --------------------
  // interrupt pin
  // --------------------
  a_irq_cause: assert property (
    $fell(irq_n) && !$past(suspend_level_irq_select) |->
      $past(hub_configured || port_power_update) ||
      ($past(hub_suspended) && !$past(hub_suspended, 2)) ||
      (!$past(charger_found_n) && $past(charger_found_n, 2)) ||
      ($past(charger_scan_done) && !$past(charger_scan_done, 2)))
    else $error("interrupt fell without an event");
  // a release only follows a register write, which ends on an scl fall
  a_irq_release: assert property (
    $rose(irq_n) && !suspend_level_irq_select &&
      !$past(suspend_level_irq_select) &&
      !$past(suspend_level_irq_select, 2) |->
      !$past(scl_in) || !$past(scl_in, 2))
    else $error("interrupt released without a write");
  a_level_low: assert property (
    (suspend_level_irq_select && hub_suspended)[*2] |-> !irq_n)
    else $error("level mode pin not low in suspend");
  a_level_high: assert property (
    (suspend_level_irq_select && !hub_suspended)[*2] |-> irq_n)
    else $error("level mode pin not high out of suspend");
endmodule

bind hsi_top hsi_top_checker u_hsi_top_checker (
  .clock(clock), .arst_n(arst_n), .scl_in(scl_in),
  .hub_suspended(hub_suspended), .hub_configured(hub_configured),
  .port_power_update(port_power_update),
  .charger_found_n(charger_found_n),
  .charger_scan_done(charger_scan_done),
  .charger_scan_stage(charger_scan_stage),
  .refclk_wait_stage(refclk_wait_stage),
  .refclk_present(refclk_present),
  .suspend_level_irq_select(suspend_level_irq_select),
  .irq_n(irq_n), .charger_scan_start(charger_scan_start),
  .charger_scan_enable(charger_scan_enable),
  .data_line_voltage_source(data_line_voltage_source)
);

`default_nettype wire

/* test/hsi_ctrl_model.sv */
// Purpose: two-wire controller standing in for the host processor
// Assumes: sda has a pull-up; this model alone drives scl
// Notes:   every phase lasts 4 clocks, signals move on falling clock edges
`default_nettype none

module hsi_ctrl_model (
  // clock
  input  wire logic clock,
  // two-wire bus
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge clock);
  endtask

  // sda moves only a phase after scl falls, so no false stop is seen
  task automatic start();
    half();
    sda_pull = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_pull = 1'b1;
    half();
    scl = 1'b0;
  endtask

  task automatic stop();
    half();
    sda_pull = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_pull = 1'b0;
    half();
  endtask

  task automatic xfer(input logic [7:0] tx, input logic rd, input logic nak,
                      output logic [7:0] rx, output logic ack);
    logic [8:0] bits;
    bits = rd ? {8'hFF, nak} : {tx, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      half();
      sda_pull = ~bits[i];
      half();
      scl = 1'b1;
      half();
      if (i > 0) begin
        rx[i-1] = sda_wire;
      end else begin
        ack = ~sda_wire;
      end
      scl = 1'b0;
    end
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic       a;
    start();
    xfer({dev, 1'b0}, 1'b0, 1'b0, rx, ok);
    xfer(ptr, 1'b0, 1'b0, rx, a);
    xfer(data, 1'b0, 1'b0, rx, a);
    stop();
  endtask

  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
                          output logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic       a;
    start();
    xfer({dev, 1'b0}, 1'b0, 1'b0, rx, ok);
    xfer(ptr, 1'b0, 1'b0, rx, a);
    start();
    xfer({dev, 1'b1}, 1'b0, 1'b0, rx, a);
    xfer(8'h00, 1'b1, 1'b1, data, a);
    stop();
  endtask
endmodule

`default_nettype wire

/* test/testbench.sv */
// Purpose: register-level test of the hub serial interrupt block
// Assumes: controller model makes all serial traffic
// Notes:   inputs change on falling clock edges only
`default_nettype none

module testbench;
  import hsi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clock, arst_n, scl, sda_pull, sda_wire, sda_out, sda_oe;
  logic       asel0, asel1, susp, cfg, ppu, fnd_n, done, stg, wst, rclk;
  logic       lvl, irq_n, start, en, dlvs, ok;
  logic [6:0] dev;
  logic [7:0] rd;
  logic [7:0] rst_val [6] = '{8'h00, 8'h00, 8'h08, 8'h28, 8'h14, 8'h00};
  int         fail_count, check_count, starts, cycles;

  assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));

  hsi_ctrl_model u_host (
    .clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull)
  );

  hsi_top u_hsi_top (
    .clock(clock), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_0(asel0),
    .addr_select_1(asel1), .hub_suspended(susp), .hub_configured(cfg),
    .port_power_update(ppu), .charger_found_n(fnd_n),
    .charger_scan_done(done), .charger_scan_stage(stg),
    .refclk_wait_stage(wst), .refclk_present(rclk),
    .suspend_level_irq_select(lvl), .irq_n(irq_n),
    .charger_scan_start(start), .charger_scan_enable(en),
    .data_line_voltage_source(dlvs)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (start === 1'b1) starts++;
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    u_host.write_reg(dev, p, d, ok);
  endtask

  task automatic rchk(input string w, input logic [7:0] p,
                      input logic [7:0] e);
    u_host.read_reg(dev, p, rd, ok);
    check(w, rd, e);
  endtask

  // restoring levels moves each input the way that is not an event
  task automatic fire(input int i);
    @(negedge clock);
    case (i)
      4: susp = 1'b1;
      3: cfg = 1'b1;
      2: ppu = 1'b1;
      1: fnd_n = 1'b0;
      default: done = 1'b1;
    endcase
    @(negedge clock);
    {susp, cfg, ppu, fnd_n, done} = 5'b00010;
    repeat (2) @(negedge clock);
  endtask

  task automatic stage_pulse(input logic wait_kind);
    @(negedge clock);
    if (wait_kind) wst = 1'b1;
    else stg = 1'b1;
    repeat (4) @(negedge clock);
    {stg, wst} = 2'b00;
    repeat (2) @(negedge clock);
  endtask

  initial begin
    {asel0, asel1, susp, cfg, ppu, done, stg, wst, lvl} = '0;
    {fnd_n, rclk} = 2'b11;
    arst_n = 1'b0;
    dev = {RST_ADDR_LOW[6:1], 1'b0};
    repeat (16) @(negedge clock);
    arst_n = 1'b1;
    repeat (4) @(negedge clock);
    check("irq_n idle", {7'h00, irq_n}, 8'h01);
    check("mode pins", {6'h00, en, dlvs}, 8'h03);
    for (int i = 0; i < 6; i++) begin
      rchk("reset value", OFS_IRQ_STATUS + i[7:0], rst_val[i]);
    end
    wr(OFS_ADDR_LOW, 8'hFF);
    rchk("read-only addr", OFS_ADDR_LOW, RST_ADDR_LOW);
    wr(OFS_CHG_MODE, 8'hFF);
    rchk("mode reserved", OFS_CHG_MODE, 8'h14);
    stage_pulse(1'b0);
    stage_pulse(1'b1);
    rclk = 1'b0;
    stage_pulse(1'b1);
    check("starts", starts[7:0], 8'h02);
    wr(OFS_CHG_MODE, 8'h00);
    rchk("mode off", OFS_CHG_MODE, 8'h00);
    check("mode pins off", {6'h00, en, dlvs}, 8'h00);
    stage_pulse(1'b0);
    check("no start", starts[7:0], 8'h02);
    wr(OFS_CHG_MODE, 8'h14);
    for (int s = 0; s < 4; s++) begin
      @(negedge clock);
      {asel1, asel0} = s[1:0];
      dev = {(s[1] ? RST_ADDR_HIGH[6:1] : RST_ADDR_LOW[6:1]), s[0]};
      repeat (4) @(negedge clock);
      u_host.write_reg(dev ^ 7'h01, OFS_IRQ_ENABLE, 8'h00, ok);
      check("wrong addr ack", {7'h00, ok}, 8'h00);
      u_host.write_reg(dev, OFS_IRQ_ENABLE, 8'h1F, ok);
      check("addr ack", {7'h00, ok}, 8'h01);
    end
    rchk("enables", OFS_IRQ_ENABLE, 8'h1F);
    for (int i = 0; i < 5; i++) begin
      fire(i);
      check("irq low", {7'h00, irq_n}, 8'h00);
      rchk("flag", OFS_IRQ_STATUS, 8'h80 | (8'h01 << i));
      wr(OFS_IRQ_STATUS, 8'hFF);
      check("irq kept", {7'h00, irq_n}, 8'h00);
      wr(OFS_IRQ_STATUS, 8'h7F);
      check("irq released", {7'h00, irq_n}, 8'h01);
      rchk("flag sticky", OFS_IRQ_STATUS, 8'h01 << i);
      wr(OFS_IRQ_STATUS, 8'h80);
      rchk("flag cleared", OFS_IRQ_STATUS, 8'h00);
    end
    wr(OFS_IRQ_ENABLE, 8'h17);
    fire(3);
    check("masked irq", {7'h00, irq_n}, 8'h01);
    fire(2);
    check("unmasked irq", {7'h00, irq_n}, 8'h00);
    rchk("two flags", OFS_IRQ_STATUS, 8'h8C);
    wr(OFS_IRQ_STATUS, 8'h7B);
    rchk("one cleared", OFS_IRQ_STATUS, 8'h08);
    check("irq after clear", {7'h00, irq_n}, 8'h01);
    wr(OFS_IRQ_ENABLE, 8'h00);
    @(negedge clock);
    {lvl, susp} = 2'b11;
    repeat (3) @(negedge clock);
    check("level irq", {7'h00, irq_n}, 8'h00);
    susp = 1'b0;
    repeat (3) @(negedge clock);
    check("level irq off", {7'h00, irq_n}, 8'h01);
    lvl = 1'b0;
    repeat (3) @(negedge clock);
    summarize();
  end
endmodule

`default_nettype wire
